// ==== verilog/sgc_pkg.sv ====
// Shared constants and types for the signal engine command decoder
package sgc_pkg;
  // Command field positions
  localparam int OP_HI = 15;
  localparam int OP_LO = 11;
  localparam int ARG_HI = 10;

  // Major opcodes
  localparam logic [4:0] OP_LOAD_VCTRL = 5'h00;
  localparam logic [4:0] OP_LOAD_LOOP  = 5'h06;
  localparam logic [4:0] OP_LOAD_EBASE = 5'h07;
  localparam logic [4:0] OP_ST_OVF     = 5'h09;
  localparam logic [4:0] OP_ST_FIRST   = 5'h0A;
  localparam logic [4:0] OP_ST_SECOND  = 5'h0B;
  localparam logic [4:0] OP_ST_THIRD   = 5'h0C;
  localparam logic [4:0] OP_ST_ACC     = 5'h0D;
  localparam logic [4:0] OP_ST_LOOP    = 5'h0E;
  localparam logic [4:0] OP_EXEC       = 5'h10;
  localparam logic [4:0] OP_HALT       = 5'h19;
  localparam logic [4:0] OP_NOP        = 5'h1A;
  localparam logic [4:0] OP_ST_FLO     = 5'h1C;
  localparam logic [4:0] OP_ST_FHI     = 5'h1D;

  // Execute-class functions
  localparam logic [10:0] FN_ADV_FIRST  = 11'h459;
  localparam logic [10:0] FN_ADV_SECOND = 11'h45B;
  localparam logic [10:0] FN_ADV_THIRD  = 11'h45D;
  localparam logic [10:0] FN_RET_FIRST  = 11'h52D;
  localparam logic [10:0] FN_RET_SECOND = 11'h52F;
  localparam logic [10:0] FN_RET_THIRD  = 11'h531;
  localparam logic [10:0] FN_ST_EXT_ACC = 11'h536;
  localparam logic [10:0] FN_LOOP_BR    = 11'h56C;
  localparam logic [10:0] FN_DEBUG_TRAP = 11'h7FE;

  // Vector pointer layout: addr[15:0], incr[19:16], wrap[24:20]
  localparam int PTR_INCR_LO = 16;
  localparam int PTR_WRAP_LO = 20;
  // Loop register layout: count[15:0], target[31:16]
  localparam int LOOP_TGT_LO = 16;

  localparam logic [15:0] RESET_PC = 16'h0000;

  // Memory request carried to RAM
  typedef struct packed {
    logic        req;
    logic        wr;
    logic        dbl;
    logic [15:0] addr;
    logic [31:0] wdata;
  } sgc_mem_req_t;

  // Termination / trap events
  typedef struct packed {
    logic halted;
    logic nmi;
    logic undef;
  } sgc_evt_t;
endpackage

// ==== verilog/sgc_engine.sv ====
// Command decoder and executor of the signal engine
// Overview of operation
// - Opcode 00000 loads vector control register from aligned double word.
// - Opcode 00110 loads the loop register from aligned double word.
// - Opcode 00111 loads the external base register from aligned double word.
// - Opcode 01010 stores the whole first pointer as a double word.
// - Opcodes 11100 and 11101 store first pointer low or high half word.
// - Opcodes 01011 and 01100 store second and third pointers.
// - Opcode 01101 stores accumulator bits 15..30 as a complex pair.
// - Function 536 stores imaginary acc bits 0..30 shifted left at third vector.
// - Opcode 01110 stores the loop register as a double word.
// - Opcode 01001 stores the overflow register, then clears it.
// - Functions 459/45B/45D advance a pointer one element with wrap.
// - Functions 52D/52F/531 move a pointer back one element with wrap.
// - Opcode 11010 does nothing and moves to the next command.
// - Opcode 11001 halts the list and signals the CPU core.
// - Loop branch decrements count, jumps to target if nonzero.
// - Debug trap function sets the undefined-command flag.
// - None of these commands alter the accumulator.
// - Reserved encodings end the list, request NMI, set undefined flag.
// - Element address keeps base bits above wrap, offset modulo wrap.
`timescale 1ns/1ps
module sgc_engine (
  input  wire logic               clock,       // Module clock
  input  wire logic               resetn,      // Async reset, active low
  input  wire logic               start,       // Begin list at start_addr
  input  wire logic [15:0]        start_addr,  // First command address
  input  wire logic [33:0]        acc_re,      // Accumulator real part
  input  wire logic [33:0]        acc_im,      // Accumulator imaginary part
  input  wire logic [15:0]        ovf_in,      // Overflow register value
  output logic                    ovf_clear,   // Clear overflow register pulse
  output sgc_pkg::sgc_mem_req_t   mem_req,     // RAM request
  input  wire logic [31:0]        mem_rdata,   // RAM read data, next cycle
  output logic [31:0]             vctrl,       // Vector control register
  output logic [31:0]             loop_reg,    // Loop register
  output logic [31:0]             ext_base,    // External base register
  output logic [31:0]             ptr_first,   // First vector pointer
  output logic [31:0]             ptr_second,  // Second vector pointer
  output logic [31:0]             ptr_third,   // Third vector pointer
  output logic                    busy,        // List running
  output sgc_pkg::sgc_evt_t       evt          // Halt/NMI/undefined flags
);
  // Sequencer states
  typedef enum logic [2:0] {SGC_IDLE, SGC_FETCH, SGC_DECODE, SGC_LOAD, SGC_STORE} sgc_state_t;

  // Registered state and next values

  sgc_state_t            state;
  sgc_state_t            next_state;
  logic [15:0]           pc;
  logic [15:0]           next_pc;
  logic [15:0]           cmd;
  logic [15:0]           next_cmd;
  sgc_pkg::sgc_mem_req_t next_mem_req;
  logic [31:0]           next_vctrl;
  logic [31:0]           next_loop_reg;
  logic [31:0]           next_ext_base;
  logic [31:0]           next_ptr_first;
  logic [31:0]           next_ptr_second;
  logic [31:0]           next_ptr_third;
  logic                  next_busy;
  logic                  next_ovf_clear;
  sgc_pkg::sgc_evt_t     next_evt;
  logic [4:0]            op;
  logic [10:0]           fn;
  logic [15:0]           arg_addr;
  logic [15:0]           loop_cnt_dec;

  // Cyclic element step: base kept above wrap bits, offset modulo 2^wrap
  function automatic logic [31:0] step_ptr(input logic [31:0] p, input logic back);
    logic [15:0] a;
    logic [15:0] inc;
    logic [15:0] msk;
    logic [15:0] sum;
    a   = p[15:0];
    inc = 16'h0001 << p[sgc_pkg::PTR_INCR_LO +: 4];
    msk = (p[sgc_pkg::PTR_WRAP_LO +: 5] >= 5'd16) ? 16'hFFFF
          : 16'((17'h0_0001 << p[sgc_pkg::PTR_WRAP_LO +: 5]) - 17'h0_0001);
    sum = back ? 16'(a - inc) : 16'(a + inc);
    step_ptr = {p[31:16], (a & ~msk) | (sum & msk)};
  endfunction

  // Fields of the held command
  assign op           = cmd[sgc_pkg::OP_HI:sgc_pkg::OP_LO];
  assign fn           = cmd[sgc_pkg::ARG_HI:0];
  assign arg_addr     = {5'h00, cmd[sgc_pkg::ARG_HI:0]};
  assign loop_cnt_dec = 16'(loop_reg[15:0] - 16'h0001);

  // Sequencer, decode and execute
  always_comb begin
    next_state      = state;
    next_pc         = pc;
    next_cmd        = cmd;
    next_mem_req    = '0;
    next_vctrl      = vctrl;
    next_loop_reg   = loop_reg;
    next_ext_base   = ext_base;
    next_ptr_first  = ptr_first;
    next_ptr_second = ptr_second;
    next_ptr_third  = ptr_third;
    next_busy       = busy;
    next_ovf_clear  = 1'b0;
    next_evt        = '0;
    case (state)
      // Wait for a start request
      SGC_IDLE: begin
        if (start) begin
          next_pc    = start_addr;
          next_busy  = 1'b1;
          next_state = SGC_FETCH;
        end
      end
      // Read the next command word
      SGC_FETCH: begin
        next_mem_req.req  = 1'b1;
        next_mem_req.addr = pc;
        next_pc           = 16'(pc + 16'h0001);
        next_state        = SGC_DECODE;
      end
      // Command word stands on the read bus this cycle
      SGC_DECODE: begin
        next_cmd   = mem_rdata[15:0];
        next_state = SGC_FETCH;
        case (mem_rdata[15:11])
          sgc_pkg::OP_LOAD_VCTRL, sgc_pkg::OP_LOAD_LOOP, sgc_pkg::OP_LOAD_EBASE: begin
            next_mem_req.req  = 1'b1;
            next_mem_req.dbl  = 1'b1;
            next_mem_req.addr = {5'h00, mem_rdata[10:1], 1'b0};
            next_state        = SGC_LOAD;
          end
          // Plain advance to the next command
          sgc_pkg::OP_NOP: begin
            next_state = SGC_FETCH;
          end
          // End of list, made visible to the CPU core
          sgc_pkg::OP_HALT: begin
            next_busy       = 1'b0;
            next_evt.halted = 1'b1;
            next_state      = SGC_IDLE;
          end
          sgc_pkg::OP_ST_OVF, sgc_pkg::OP_ST_FIRST, sgc_pkg::OP_ST_SECOND, sgc_pkg::OP_ST_THIRD,
          sgc_pkg::OP_ST_ACC, sgc_pkg::OP_ST_LOOP, sgc_pkg::OP_ST_FLO, sgc_pkg::OP_ST_FHI: begin
            // Register stores write in the following cycle
            next_state = SGC_STORE;
          end
          // Execute class, function in the low eleven bits
          sgc_pkg::OP_EXEC: begin
            case (mem_rdata[10:0])
              // Pointer advance by one element
              sgc_pkg::FN_ADV_FIRST: begin
                next_ptr_first  = step_ptr(ptr_first, 1'b0);
              end
              sgc_pkg::FN_ADV_SECOND: begin
                next_ptr_second = step_ptr(ptr_second, 1'b0);
              end
              sgc_pkg::FN_ADV_THIRD: begin
                next_ptr_third  = step_ptr(ptr_third, 1'b0);
              end
              // Pointer retreat by one element
              sgc_pkg::FN_RET_FIRST: begin
                next_ptr_first  = step_ptr(ptr_first, 1'b1);
              end
              sgc_pkg::FN_RET_SECOND: begin
                next_ptr_second = step_ptr(ptr_second, 1'b1);
              end
              sgc_pkg::FN_RET_THIRD: begin
                next_ptr_third  = step_ptr(ptr_third, 1'b1);
              end
              // Extended accumulator store runs as a store cycle
              sgc_pkg::FN_ST_EXT_ACC: begin
                next_state = SGC_STORE;
              end
              // Count down, jump back while the count stays nonzero
              sgc_pkg::FN_LOOP_BR: begin
                next_loop_reg[15:0] = loop_cnt_dec;
                if (loop_cnt_dec != 16'h0000) begin
                  next_pc = loop_reg[sgc_pkg::LOOP_TGT_LO +: 16];
                end
              end
              // Breakpoint flags but keeps the list running
              sgc_pkg::FN_DEBUG_TRAP: begin
                next_evt.undef = 1'b1;
              end
              // Reserved function ends the list
              default: begin
                next_evt.undef = 1'b1;
                next_evt.nmi   = 1'b1;
                next_busy      = 1'b0;
                next_state     = SGC_IDLE;
              end
            endcase
          end
          // Reserved major opcode ends the list
          default: begin
            next_evt.undef = 1'b1;
            next_evt.nmi   = 1'b1;
            next_busy      = 1'b0;
            next_state     = SGC_IDLE;
          end
        endcase
      end
      // Loaded double word stands on the read bus this cycle
      SGC_LOAD: begin
        next_state = SGC_FETCH;
        case (op)
          sgc_pkg::OP_LOAD_VCTRL: begin
            next_vctrl    = mem_rdata;
          end
          sgc_pkg::OP_LOAD_LOOP: begin
            next_loop_reg = mem_rdata;
          end
          default: begin
            next_ext_base = mem_rdata;
          end
        endcase
      end
      SGC_STORE: begin
        // Accumulator is only read here, never written
        next_state        = SGC_FETCH;
        next_mem_req.req  = 1'b1;
        next_mem_req.wr   = 1'b1;
        next_mem_req.dbl  = 1'b1;
        next_mem_req.addr = {arg_addr[15:1], 1'b0};
        case (op)
          // Whole double word stores
          sgc_pkg::OP_ST_FIRST: begin
            next_mem_req.wdata = ptr_first;
          end
          sgc_pkg::OP_ST_SECOND: begin
            next_mem_req.wdata = ptr_second;
          end
          sgc_pkg::OP_ST_THIRD: begin
            next_mem_req.wdata = ptr_third;
          end
          sgc_pkg::OP_ST_LOOP: begin
            next_mem_req.wdata = loop_reg;
          end
          // Complex pair, imaginary in the upper word
          sgc_pkg::OP_ST_ACC: begin
            next_mem_req.wdata = {acc_im[30:15], acc_re[30:15]};
          end
          // Half pointer stores, one word each
          sgc_pkg::OP_ST_FLO, sgc_pkg::OP_ST_FHI: begin
            next_mem_req.dbl   = 1'b0;
            next_mem_req.addr  = arg_addr;
            next_mem_req.wdata = {16'h0000, (op == sgc_pkg::OP_ST_FHI) ? ptr_first[31:16] : ptr_first[15:0]};
          end
          // Overflow word store with clear pulse
          sgc_pkg::OP_ST_OVF: begin
            next_mem_req.dbl   = 1'b0;
            next_mem_req.addr  = arg_addr;
            next_mem_req.wdata = {16'h0000, ovf_in};
            next_ovf_clear     = 1'b1;
          end
          // Extended accumulator at the third pointer, bit 0 zero
          default: begin
            next_mem_req.addr  = ptr_third[15:0];
            next_mem_req.wdata = {acc_im[30:0], 1'b0};
          end
        endcase
      end
      // Unused state codes fall back to idle
      default: begin
        next_state = SGC_IDLE;
      end
    endcase
  end

  // State registers
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      state      <= SGC_IDLE;
      pc         <= sgc_pkg::RESET_PC;
      cmd        <= 16'h0000;
      mem_req    <= '0;
      vctrl      <= 32'h0000_0000;
      loop_reg   <= 32'h0000_0000;
      ext_base   <= 32'h0000_0000;
      ptr_first  <= 32'h0000_0000;
      ptr_second <= 32'h0000_0000;
      ptr_third  <= 32'h0000_0000;
      busy       <= 1'b0;
      ovf_clear  <= 1'b0;
      evt        <= '0;
    end else begin
      state      <= next_state;
      pc         <= next_pc;
      cmd        <= next_cmd;
      mem_req    <= next_mem_req;
      vctrl      <= next_vctrl;
      loop_reg   <= next_loop_reg;
      ext_base   <= next_ext_base;
      ptr_first  <= next_ptr_first;
      ptr_second <= next_ptr_second;
      ptr_third  <= next_ptr_third;
      busy       <= next_busy;
      ovf_clear  <= next_ovf_clear;
      evt        <= next_evt;
    end
  end
endmodule

// ==== verification/sgc_ram_model.sv ====
// Command and data RAM that faces the engine's memory port
`timescale 1ns/1ps
module sgc_ram_model (
  input  wire logic                  clock,  // Module clock
  input  wire sgc_pkg::sgc_mem_req_t req,    // Request from the engine
  output logic [31:0]                rdata   // Read data, same cycle as the request
);
  logic [15:0] mem [0:255];
  logic [31:0] last;
  initial last = 32'h0000_0000;
  // Stores whole units and remembers the last word read
  always @(posedge clock) begin
    if (req.req && req.wr) begin
      mem[req.addr[7:0]] <= req.wdata[15:0];
      if (req.dbl) mem[req.addr[7:0] + 8'h01] <= req.wdata[31:16];
    end
    if (req.req && !req.wr) last <= rdata;
  end
  // Read data stands while the registered read request stands; idle bus shows the inverse
  assign rdata = (req.req && !req.wr) ? {mem[req.addr[7:0] + 8'h01], mem[req.addr[7:0]]} : ~last;
endmodule

// ==== verification/sgc_engine_asserts.sv ====
// Port assertions for the engine
`timescale 1ns/1ps
module sgc_engine_asserts (
  input wire logic                  clock,      // Module clock
  input wire logic                  resetn,     // Async reset, active low
  input wire logic [15:0]           ovf_in,     // Overflow value
  input wire logic                  ovf_clear,  // Overflow clear pulse
  input wire sgc_pkg::sgc_mem_req_t mem_req,    // RAM request
  input wire logic [31:0]           vctrl,      // Vector control
  input wire logic [31:0]           loop_reg,   // Loop register
  input wire logic [31:0]           ext_base,   // External base
  input wire logic [31:0]           ptr_first,  // First pointer
  input wire logic                  busy,       // List running
  input wire sgc_pkg::sgc_evt_t     evt         // Events
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (!resetn);
  // Termination and trap events
  property p_halt_idle; evt.halted |-> !busy && !evt.nmi; endproperty
  a_halt_idle: assert property (p_halt_idle) else $error("halt event while busy");
  property p_halt_quiet; evt.halted |=> (!mem_req.req) [*3]; endproperty
  a_halt_quiet: assert property (p_halt_quiet) else $error("access after halt");
  property p_reserved; evt.nmi |-> evt.undef && !busy; endproperty
  a_reserved: assert property (p_reserved) else $error("reserved code events wrong");
  property p_undef_pulse; evt.undef |=> !evt.undef; endproperty
  a_undef_pulse: assert property (p_undef_pulse) else $error("undefined flag not a pulse");
  // Memory traffic and idle register hold
  property p_ovf_store; ovf_clear |-> mem_req.req && mem_req.wr && !mem_req.dbl && mem_req.wdata[15:0] == ovf_in; endproperty
  a_ovf_store: assert property (p_ovf_store) else $error("overflow clear without its store");
  property p_dbl_even; mem_req.req && mem_req.dbl |-> !mem_req.addr[0]; endproperty
  a_dbl_even: assert property (p_dbl_even) else $error("double word at odd address");
  property p_first_fetch; $rose(busy) |=> mem_req.req && !mem_req.wr; endproperty
  a_first_fetch: assert property (p_first_fetch) else $error("no fetch after start");
  property p_idle_hold; !busy && !$past(busy) |-> $stable(vctrl) && $stable(loop_reg) && $stable(ext_base) && $stable(ptr_first); endproperty
  a_idle_hold: assert property (p_idle_hold) else $error("register changed while idle");
endmodule
bind sgc_engine sgc_engine_asserts u_asserts (.clock, .resetn, .ovf_in, .ovf_clear, .mem_req, .vctrl, .loop_reg,
  .ext_base, .ptr_first, .busy, .evt);

// ==== verification/sgc_engine_tb.sv ====
// Self-checking bench for the engine
`timescale 1ns/1ps
module sgc_engine_tb;
  typedef struct packed {logic [15:0] cmd; logic [2:0] kind; logic [15:0] addr; logic [31:0] data;} sgc_row_t;
  localparam logic [15:0] halt_cmd = {sgc_pkg::OP_HALT, 11'h000};
  logic clock, resetn, start, ovf_clear, busy;
  logic [15:0] start_addr, ovf_in, w_addr;
  logic [33:0] acc_re, acc_im;
  logic [31:0] mem_rdata, vctrl, loop_reg, ext_base, ptr_first, ptr_second, ptr_third, w_data;
  sgc_pkg::sgc_mem_req_t mem_req;
  sgc_pkg::sgc_evt_t evt;
  int n_errors = 0, n_tests = 0, n_halt = 0, n_undef = 0, n_nmi = 0, n_ovf = 0, n_loop = 0, cycles = 0;
  sgc_row_t rows [14] = '{
    '{{sgc_pkg::OP_LOAD_VCTRL, 11'h040}, 3'd2, 16'h0000, 32'h1234_5678},
    '{{sgc_pkg::OP_LOAD_LOOP, 11'h040}, 3'd3, 16'h0000, 32'h1234_5678},
    '{{sgc_pkg::OP_LOAD_EBASE, 11'h040}, 3'd4, 16'h0000, 32'h1234_5678},
    '{{sgc_pkg::OP_ST_LOOP, 11'h050}, 3'd0, 16'h0050, 32'h1234_5678},
    '{{sgc_pkg::OP_ST_FIRST, 11'h052}, 3'd0, 16'h0052, 32'h0000_0000},
    '{{sgc_pkg::OP_ST_ACC, 11'h058}, 3'd0, 16'h0058, 32'h3C5A_A5C3},
    '{{sgc_pkg::OP_ST_SECOND, 11'h054}, 3'd0, 16'h0054, 32'h0000_0000},
    '{{sgc_pkg::OP_ST_OVF, 11'h05A}, 3'd1, 16'h005A, 32'h0000_BEEF},
    '{{sgc_pkg::OP_ST_THIRD, 11'h056}, 3'd0, 16'h0056, 32'h0000_0000},
    '{{sgc_pkg::OP_ST_FLO, 11'h05B}, 3'd1, 16'h005B, 32'h0000_0000},
    '{{sgc_pkg::OP_ST_LOOP, 11'h05C}, 3'd0, 16'h005C, 32'h1234_5678},
    '{{sgc_pkg::OP_ST_FHI, 11'h05F}, 3'd1, 16'h005F, 32'h0000_0000},
    '{{sgc_pkg::OP_EXEC, sgc_pkg::FN_ST_EXT_ACC}, 3'd0, 16'h0000, 32'h3C5A_2468},
    '{{sgc_pkg::OP_NOP, 11'h000}, 3'd5, 16'h0000, 32'h0000_0000}};
  sgc_engine uut (.clock, .resetn, .start, .start_addr, .acc_re, .acc_im, .ovf_in, .ovf_clear, .mem_req,
    .mem_rdata, .vctrl, .loop_reg, .ext_base, .ptr_first, .ptr_second, .ptr_third, .busy, .evt);
  sgc_ram_model ram (.clock, .req(mem_req), .rdata(mem_rdata));
  always #4 clock = ~clock;
  // Event tally, write capture and hang limit
  always @(posedge clock) begin
    cycles <= cycles + 1;
    if (mem_req.req === 1'b1 && mem_req.wr === 1'b1) {w_addr, w_data} <= {mem_req.addr, mem_req.wdata};
    if (mem_req.req === 1'b1 && mem_req.wr === 1'b0 && mem_req.addr === 16'h0031) n_loop <= n_loop + 1;
    if (evt.halted === 1'b1) n_halt <= n_halt + 1;
    if (evt.undef === 1'b1) n_undef <= n_undef + 1;
    if (evt.nmi === 1'b1) n_nmi <= n_nmi + 1;
    if (ovf_clear === 1'b1) n_ovf <= n_ovf + 1;
    if (cycles == 5000) begin
      n_errors++;
      report_and_stop();
    end
  end
  function automatic logic [31:0] seen(input logic [2:0] k);
    case (k)
      3'd1: return {16'h0000, w_data[15:0]};
      3'd2: return vctrl;
      3'd3: return loop_reg;
      3'd4: return ext_base;
      3'd5: return {16'h0000, w_addr};
      default: return w_data;
    endcase
  endfunction
  task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
    n_tests++;
    if (got !== exp) begin
      n_errors++;
      $display("[FAIL] %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic run(input logic [15:0] at);
    start_addr = at;
    start = 1'b1;
    @(negedge clock);
    start = 1'b0;
    repeat (2) @(negedge clock);
    while (busy === 1'b1) @(negedge clock);
    repeat (4) @(negedge clock);
  endtask
  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  // Reset, table of single commands, then loop, pointer and trap cases
  initial begin
    int h;
    {clock, resetn, start, start_addr, ovf_in} = {3'b000, 16'h0000, 16'hBEEF};
    acc_re = {3'b101, 16'hA5C3, 15'h7FFF};
    acc_im = {3'b010, 16'h3C5A, 15'h1234};
    {ram.mem[8'h41], ram.mem[8'h40]} = 32'h1234_5678; // Nonzero length
    {ram.mem[8'h45], ram.mem[8'h44]} = 32'h0031_0003;
    repeat (2) @(negedge clock);
    resetn = 1'b1;
    check("reset_state", 32'h0000_0000, {27'h0, busy, evt, mem_req.req} | vctrl | loop_reg | ptr_first);
    $display("reset test done");
    foreach (rows[i]) begin
      h = n_halt;
      {ram.mem[8'h20], ram.mem[8'h21]} = {rows[i].cmd, halt_cmd};
      run(16'h0020);
      check("halt_count", 32'(h + 1), 32'(n_halt));
      if (rows[i].kind < 3'd2) check("write_addr", {16'h0000, rows[i].addr}, {16'h0000, w_addr});
      check("value", rows[i].data, seen(rows[i].kind));
      $display("row %0d done", i);
    end
    check("ovf_clear_count", 32'h0000_0001, 32'(n_ovf));
    {ram.mem[8'h30], ram.mem[8'h31]} = {sgc_pkg::OP_LOAD_LOOP, 11'h044, sgc_pkg::OP_NOP, 11'h000};
    {ram.mem[8'h32], ram.mem[8'h33]} = {sgc_pkg::OP_EXEC, sgc_pkg::FN_LOOP_BR, halt_cmd};
    h = n_loop;
    run(16'h0030);
    check("loop_passes", 32'(h + 3), 32'(n_loop));
    check("loop_final", 32'h0031_0000, loop_reg);
    $display("loop test done");
    {ram.mem[8'h38], ram.mem[8'h39], ram.mem[8'h3A]} = {5'h10, sgc_pkg::FN_ADV_FIRST, 5'h10, sgc_pkg::FN_ADV_SECOND,
      5'h10, sgc_pkg::FN_ADV_THIRD};
    {ram.mem[8'h3B], ram.mem[8'h3C], ram.mem[8'h3D]} = {5'h10, sgc_pkg::FN_RET_FIRST, 5'h10, sgc_pkg::FN_RET_SECOND,
      5'h10, sgc_pkg::FN_RET_THIRD};
    ram.mem[8'h3E] = halt_cmd;
    run(16'h0038);
    check("ptr_round_trip", 32'h0000_0000, ptr_first | ptr_second | ptr_third);
    $display("pointer test done");
    {ram.mem[8'h20], ram.mem[8'h21]} = {sgc_pkg::OP_EXEC, sgc_pkg::FN_DEBUG_TRAP, halt_cmd};
    h = n_undef;
    run(16'h0020);
    check("trap_flag", 32'(h + 1), 32'(n_undef));
    ram.mem[8'h20] = 16'hF800;
    h = n_nmi + n_undef + n_halt;
    run(16'h0020);
    check("reserved_events", 32'(h + 2), 32'(n_nmi + n_undef + n_halt));
    $display("trap tests done");
    report_and_stop();
  end
endmodule
